// ### rtl/idp_pkg.sv
// idp_pkg: constants, types and register map of the indirect data pointer unit.
// assumes one core clock and an apb slave with one register per aligned 32-bit word.
package idp_pkg;

  // widths and memory depth
  localparam int        PADDR_W     = 8;
  localparam int        DMEM_ADDR_W = 12;
  localparam int        DMEM_DEPTH  = 4096;
  localparam int        NUM_PTR     = 2;

  // register map: byte address = {set, slot, 2'b00}
  localparam logic [7:0] SET1_BASE        = 8'h20;
  localparam logic [7:0] OFS_PLAIN        = 8'h00;
  localparam logic [7:0] OFS_POSTINC      = 8'h04;
  localparam logic [7:0] OFS_POSTDEC      = 8'h08;
  localparam logic [7:0] OFS_PREINC       = 8'h0c;
  localparam logic [7:0] OFS_OFFSET       = 8'h10;
  localparam logic [7:0] OFS_PTR_HIGH     = 8'h14;
  localparam logic [7:0] OFS_PTR_LOW      = 8'h18;
  localparam logic [7:0] OFS_WORKING_ACC  = 8'h1c;

  // field positions inside the byte address
  localparam int        ADDR_SET_BIT   = 5;
  localparam int        ADDR_SLOT_LSB  = 2;
  localparam int        ADDR_SLOT_MSB  = 4;

  // values after reset
  localparam logic [3:0] PTR_HIGH_RESET = 4'h0;
  localparam logic [7:0] RDATA_RESET    = 8'h00;

  // cycles from the setup edge to the edge at which pready is sampled high
  localparam int        ANSWER_CYCLES  = 2;

  // slot within one pointer set
  typedef enum logic [2:0] {
    SLOT_PLAIN    = 3'b000,
    SLOT_POSTINC  = 3'b001,
    SLOT_POSTDEC  = 3'b010,
    SLOT_PREINC   = 3'b011,
    SLOT_OFFSET   = 3'b100,
    SLOT_PTR_HIGH = 3'b101,
    SLOT_PTR_LOW  = 3'b110,
    SLOT_WORKING  = 3'b111
  } idp_slot_e;

  // apb transfer state
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DONE = 2'b10
  } idp_state_e;

  // request to the data memory
  typedef struct packed {
    logic                   we;
    logic [DMEM_ADDR_W-1:0] addr;
    logic [7:0]             wdata;
  } idp_mem_req_s;

endpackage : idp_pkg

// ### rtl/idp_data_mem.sv
// idp_data_mem: byte-wide data memory reached by the indirect pointers.
// assumes one request per cycle; read data is registered, a read beside a write sees old data.
module idp_data_mem
  import idp_pkg::*;
(
  // clock
  input  wire logic                  pclk,
  // request and answer
  input  wire idp_pkg::idp_mem_req_s req,
  output logic [7:0]                 rdata
);

  // contents power up unknown, so no reset on the array
  logic [7:0] mem [DMEM_DEPTH];

  // write port
  always_ff @(posedge pclk) begin
    if (req.we) begin
      mem[req.addr] <= req.wdata;
    end
  end

  // registered read port
  always_ff @(posedge pclk) begin
    rdata <= mem[req.addr];
  end

endmodule : idp_data_mem

// ### rtl/idp_indirect_pointer_unit.sv
// idp_indirect_pointer_unit: two address pointer sets with their virtual operands.
// assumes an apb master on pclk; the data memory sits in idp_data_mem below this module.
//
// Operation
// - a virtual operand has no storage and reads or writes the data byte its pointer addresses.
// - the post-decrement operand uses the pointer as address and then lowers it by one.
// - the pre-increment operand first raises the pointer by one and uses the new value.
// - the offset operand addresses pointer plus working register and leaves the pointer alone.
// - the pointer high byte keeps four bits, cleared at reset, while the low byte powers up unknown.
// - each pointer is twelve bits wide and reaches any data byte without banking.
//
// Our own choices: the register offsets and the APB register port.
module idp_indirect_pointer_unit
  import idp_pkg::*;
(
  // clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // apb request
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [idp_pkg::PADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  input  wire logic [3:0]                  pstrb,
  // apb answer
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  idp_state_e               state;
  idp_state_e               next_state;

  // pointer storage, split so that only the high bits carry a reset
  logic [3:0]               ptr_high [NUM_PTR];
  logic [7:0]               ptr_low  [NUM_PTR];
  logic [DMEM_ADDR_W-1:0]   ptr      [NUM_PTR];
  logic [DMEM_ADDR_W-1:0]   next_ptr [NUM_PTR];
  logic                     ptr_upd  [NUM_PTR];
  logic [7:0]               working_accumulator;

  // decode of the setup cycle
  logic                     setup;
  logic                     dec_set;
  idp_slot_e                dec_slot;
  logic                     dec_ok;
  logic [DMEM_ADDR_W-1:0]   dec_ptr;
  logic [DMEM_ADDR_W-1:0]   eff_addr;

  // transfer captured at the setup edge
  logic                     acc_set;
  idp_slot_e                acc_slot;
  logic                     acc_ok;
  logic                     acc_ind;
  logic                     acc_write;
  logic [DMEM_ADDR_W-1:0]   acc_addr;

  // commit strobes at the completing edge
  logic                     commit;
  logic                     wr_commit;

  // memory side
  idp_mem_req_s             mem_req;
  logic [7:0]               mem_rdata;
  logic [7:0]               direct_rdata;

  //////////////////////////////////////////////////////////////////////////////
  // apb decode

  // a setup cycle is only taken while no transfer is in flight
  assign setup    = (state == ST_IDLE) && psel && !penable;
  assign dec_set  = paddr[ADDR_SET_BIT];
  assign dec_slot = idp_slot_e'(paddr[ADDR_SLOT_MSB:ADDR_SLOT_LSB]);
  assign dec_ptr  = ptr[dec_set];

  // set 1 has no working register slot; misaligned or high addresses are refused
  assign dec_ok = (paddr[7:6] == 2'b00) && (paddr[1:0] == 2'b00)
                  && !(dec_set && (dec_slot == SLOT_WORKING));

  // data address of the operand, before any pointer change
  always_comb begin
    eff_addr = dec_ptr;
    unique case (dec_slot)
      SLOT_PREINC: begin
        eff_addr = dec_ptr + 12'h001;
      end
      SLOT_OFFSET: begin
        eff_addr = dec_ptr + {4'h0, working_accumulator};
      end
      SLOT_PLAIN, SLOT_POSTINC, SLOT_POSTDEC,
      SLOT_PTR_HIGH, SLOT_PTR_LOW, SLOT_WORKING: begin
        eff_addr = dec_ptr;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // transfer sequencing

  // idle -> wait -> done; pready stands high during done only
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (setup) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        next_state = ST_DONE;
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // capture of the transfer; address is frozen so pointer updates cannot skew it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_set   <= 1'b0;
      acc_slot  <= SLOT_PLAIN;
      acc_ok    <= 1'b0;
      acc_ind   <= 1'b0;
      acc_write <= 1'b0;
      acc_addr  <= '0;
    end else if (setup) begin
      acc_set   <= dec_set;
      acc_slot  <= dec_slot;
      acc_ok    <= dec_ok;
      acc_ind   <= (dec_slot <= SLOT_OFFSET);
      acc_write <= pwrite;
      acc_addr  <= eff_addr;
    end
  end

  // the master holds pwdata and pstrb until this edge, so writes land here
  assign commit    = (state == ST_DONE) && acc_ok;
  assign wr_commit = commit && acc_write && pstrb[0];

  //////////////////////////////////////////////////////////////////////////////
  // answer

  // value of the direct registers
  always_comb begin
    direct_rdata = RDATA_RESET;
    if (acc_slot == SLOT_PTR_HIGH) begin
      direct_rdata = {4'h0, ptr_high[acc_set]};
    end else if (acc_slot == SLOT_PTR_LOW) begin
      direct_rdata = ptr_low[acc_set];
    end else if (acc_slot == SLOT_WORKING) begin
      direct_rdata = working_accumulator;
    end
  end

  // read data and pready raised one cycle after the memory read was issued
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (state == ST_WAIT) begin
      pready  <= 1'b1;
      pslverr <= !acc_ok;
      if (acc_ok && !acc_write) begin
        prdata <= {24'h0, acc_ind ? mem_rdata : direct_rdata};
      end else begin
        prdata <= '0;
      end
    end else begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // data memory

  // read issued at the setup edge; write at the completing edge
  always_comb begin
    mem_req.we    = wr_commit && acc_ind;
    mem_req.addr  = (state == ST_IDLE) ? eff_addr : acc_addr;
    mem_req.wdata = pwdata[7:0];
  end

  idp_data_mem u_data_mem (
    .pclk  (pclk),
    .req   (mem_req),
    .rdata (mem_rdata)
  );

  //////////////////////////////////////////////////////////////////////////////
  // working register

  // no reset: powers up unknown like any data register
  always_ff @(posedge pclk) begin
    if (wr_commit && !acc_set && (acc_slot == SLOT_WORKING)) begin
      working_accumulator <= pwdata[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pointer sets

  genvar g;
  generate
    for (g = 0; g < NUM_PTR; g++) begin : g_ptr
      assign ptr[g] = {ptr_high[g], ptr_low[g]};

      // pointer change after the access, carry runs across both bytes
      always_comb begin
        next_ptr[g] = ptr[g];
        ptr_upd[g]  = 1'b0;
        if (commit && (acc_set == 1'(g))) begin
          unique case (acc_slot)
            SLOT_POSTINC, SLOT_PREINC: begin
              next_ptr[g] = ptr[g] + 12'h001;
              ptr_upd[g]  = 1'b1;
            end
            SLOT_POSTDEC: begin
              next_ptr[g] = ptr[g] - 12'h001;
              ptr_upd[g]  = 1'b1;
            end
            SLOT_PTR_HIGH: begin
              next_ptr[g] = {pwdata[3:0], ptr_low[g]};
              ptr_upd[g]  = wr_commit;
            end
            SLOT_PTR_LOW: begin
              next_ptr[g] = {ptr_high[g], pwdata[7:0]};
              ptr_upd[g]  = wr_commit;
            end
            SLOT_PLAIN, SLOT_OFFSET, SLOT_WORKING: begin
              next_ptr[g] = ptr[g];
              ptr_upd[g]  = 1'b0;
            end
          endcase
        end
      end

      // high nibble clears at reset
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ptr_high[g] <= PTR_HIGH_RESET;
        end else if (ptr_upd[g]) begin
          ptr_high[g] <= next_ptr[g][11:8];
        end
      end

      // low byte has no reset and powers up unknown
      always_ff @(posedge pclk) begin
        if (ptr_upd[g]) begin
          ptr_low[g] <= next_ptr[g][7:0];
        end
      end

      // checks on the operand behaviour of this set
      plain_hold_a : assert property (@(posedge pclk) disable iff (!presetn)
        (commit && acc_set == 1'(g) && acc_slot == SLOT_PLAIN)
          |-> acc_addr == ptr[g] ##1 ptr[g] == $past(ptr[g]))
        else $error("plain operand moved its pointer");
      postinc_step_a : assert property (@(posedge pclk) disable iff (!presetn)
        (commit && acc_set == 1'(g) && acc_slot == SLOT_POSTINC)
          |-> acc_addr == ptr[g] ##1 ptr[g] == $past(ptr[g]) + 12'h001)
        else $error("post-increment wrong address or step");
      postdec_step_a : assert property (@(posedge pclk) disable iff (!presetn)
        (commit && acc_set == 1'(g) && acc_slot == SLOT_POSTDEC)
          |-> acc_addr == ptr[g] ##1 ptr[g] == $past(ptr[g]) - 12'h001)
        else $error("post-decrement wrong address or step");
      preinc_addr_a : assert property (@(posedge pclk) disable iff (!presetn)
        (commit && acc_set == 1'(g) && acc_slot == SLOT_PREINC)
          |-> acc_addr == ptr[g] + 12'h001 ##1 ptr[g] == $past(acc_addr))
        else $error("pre-increment did not use the raised pointer");
      offset_addr_a : assert property (@(posedge pclk) disable iff (!presetn)
        (commit && acc_set == 1'(g) && acc_slot == SLOT_OFFSET)
          |-> acc_addr == ptr[g] + {4'h0, working_accumulator} ##1 $stable(ptr[g]))
        else $error("offset operand wrong address or pointer moved");
      ptr_width_a : assert property (@(posedge pclk) disable iff (!presetn)
        (setup && dec_ok && dec_set == 1'(g) && dec_slot == SLOT_PLAIN)
          |=> acc_addr == $past(ptr[g]))
        else $error("pointer did not reach the full data address");
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // transfer checks

  answer_timing_a : assert property (@(posedge pclk) disable iff (!presetn)
    setup |=> !pready ##1 pready ##1 !pready)
    else $error("pready not high exactly in the second access cycle");

  operand_read_a : assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_WAIT && acc_ok && acc_ind && !acc_write)
      |=> pready && prdata == {24'h0, $past(mem_rdata)})
    else $error("operand read did not return the addressed data byte");

  operand_write_a : assert property (@(posedge pclk) disable iff (!presetn)
    (commit && acc_ind && acc_write && pstrb[0])
      |-> mem_req.we && mem_req.addr == acc_addr && mem_req.wdata == pwdata[7:0])
    else $error("operand write did not reach the data memory");

  high_nibble_a : assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_WAIT && acc_ok && !acc_write && acc_slot == SLOT_PTR_HIGH)
      |=> prdata[31:4] == 28'h0 && prdata[3:0] == $past(ptr_high[acc_set]))
    else $error("pointer high byte upper bits not zero");

endmodule : idp_indirect_pointer_unit

// ### testbench/idp_core_model.sv
// idp_core_model: behavioural core datapath that reaches the pointer unit as an apb master.
// assumes the unit answers with pready on pclk; a wait is cut off after 20 edges.
module idp_core_model
  import idp_pkg::*;
(
  // clock
  input  wire logic                        pclk,
  // apb request
  output logic                             psel,
  output logic                             penable,
  output logic                             pwrite,
  output logic      [idp_pkg::PADDR_W-1:0] paddr,
  output logic      [31:0]                 pwdata,
  output logic      [3:0]                  pstrb,
  // apb answer
  input  wire logic [31:0]                 prdata,
  input  wire logic                        pready,
  input  wire logic                        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////////
  // idle bus at time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
    pstrb   = '0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one transfer; request held until pready is seen high at an edge
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                      input logic [3:0] st, output logic [31:0] rd, output logic err,
                      output logic tout);
    int n;
    n    = 0;
    tout = 1'b0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    pstrb   <= st;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    tout = (pready !== 1'b1);
    rd   = prdata;
    err  = pslverr;
    // released lines show inverted values so stale data is never mistaken for a hold
    psel    <= 1'b0;
    penable <= 1'b0;
    pwrite  <= ~wr;
    paddr   <= ~addr;
    pwdata  <= ~wd;
    pstrb   <= ~st;
  endtask : xfer
endmodule : idp_core_model

// ### testbench/indirect_data_pointer_unit_tb.sv
// indirect_data_pointer_unit_tb: self-checking bench for the indirect pointer unit.
// assumes idp_core_model as the apb master; data memory is only seen through the operands.
module indirect_data_pointer_unit_tb
  import idp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                pclk;
  logic                presetn;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [PADDR_W-1:0]  paddr;
  logic [31:0]         pwdata;
  logic [3:0]          pstrb;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  int                  err_count;
  int                  checks;

  ////////////////////////////////////////////////////////////////////////////////
  // clock, 5 ns period
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  idp_indirect_pointer_unit dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr)
  );

  idp_core_model core (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // comparison and reporting
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // bus access; a hung transfer ends the run
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     input logic [3:0] st, output logic [31:0] rd, output logic err);
    logic tout;
    core.xfer(wr, a, wd, st, rd, err, tout);
    if (tout) begin
      err_count++;
      $display("[FAIL] %0t ns: no pready within bound", $time);
      tally_and_finish();
    end
  endtask : acc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic        err;
    acc(1'b1, a, {24'h0, d}, 4'hf, rd, err);
  endtask : wr

  // read with expected word and no error
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        err;
    acc(1'b0, a, 32'h0, 4'h0, r, err);
    check(r, exp);
    check({31'h0, err}, 32'h0);
  endtask : rd

  task automatic set_ptr(input logic [7:0] base, input logic [11:0] v);
    wr(base + OFS_PTR_HIGH, {4'h0, v[11:8]});
    wr(base + OFS_PTR_LOW, v[7:0]);
  endtask : set_ptr

  task automatic rd_ptr(input logic [7:0] base, input logic [11:0] exp);
    rd(base + OFS_PTR_HIGH, {28'h0, exp[11:8]});
    rd(base + OFS_PTR_LOW, {24'h0, exp[7:0]});
  endtask : rd_ptr

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic sc_reset();
    rd(OFS_PTR_HIGH, 32'h0);
    rd(SET1_BASE + OFS_PTR_HIGH, 32'h0);
  endtask : sc_reset

  // post-increment carries across the byte boundary
  task automatic sc_postinc();
    set_ptr(8'h00, 12'h0fe);
    wr(OFS_POSTINC, 8'ha1);
    wr(OFS_POSTINC, 8'ha2);
    wr(OFS_POSTINC, 8'ha3);
    rd_ptr(8'h00, 12'h101);
    set_ptr(8'h00, 12'h0fe);
    rd(OFS_PLAIN, 32'ha1);
    rd(OFS_PLAIN, 32'ha1);
    rd(OFS_POSTINC, 32'ha1);
    rd(OFS_POSTINC, 32'ha2);
    rd(OFS_POSTINC, 32'ha3);
  endtask : sc_postinc

  // post-decrement wraps below zero, pre-increment wraps above the top
  task automatic sc_dec_inc();
    set_ptr(8'h00, 12'h001);
    wr(OFS_POSTDEC, 8'hb1);
    wr(OFS_POSTDEC, 8'hb0);
    rd_ptr(8'h00, 12'hfff);
    rd(OFS_PREINC, 32'hb0);
    rd(OFS_PREINC, 32'hb1);
    rd_ptr(8'h00, 12'h001);
  endtask : sc_dec_inc

  // offset address wraps mod 4096 and the pointer stays put
  task automatic sc_offset();
    set_ptr(8'h00, 12'hffe);
    wr(OFS_WORKING_ACC, 8'h03);
    wr(OFS_OFFSET, 8'hc5);
    rd_ptr(8'h00, 12'hffe);
    rd(OFS_WORKING_ACC, 32'h03);
    rd(OFS_OFFSET, 32'hc5);
    set_ptr(SET1_BASE, 12'h001);
    rd(SET1_BASE + OFS_PLAIN, 32'hc5);
    rd(SET1_BASE + OFS_POSTDEC, 32'hc5);
    rd_ptr(SET1_BASE, 12'h000);
    rd_ptr(8'h00, 12'hffe);
  endtask : sc_offset

  // set 1 through its increment and offset operands; set 0 must not move
  task automatic sc_set1();
    set_ptr(SET1_BASE, 12'h7ff);
    wr(SET1_BASE + OFS_POSTINC, 8'hd1);
    wr(SET1_BASE + OFS_PREINC, 8'hd3);
    rd_ptr(SET1_BASE, 12'h801);
    set_ptr(SET1_BASE, 12'h7fc);
    rd(SET1_BASE + OFS_OFFSET, 32'hd1);
    rd_ptr(SET1_BASE, 12'h7fc);
    set_ptr(SET1_BASE, 12'h800);
    rd(SET1_BASE + OFS_PREINC, 32'hd3);
    rd(SET1_BASE + OFS_POSTINC, 32'hd3);
    rd_ptr(SET1_BASE, 12'h802);
    rd_ptr(8'h00, 12'hffe);
  endtask : sc_set1

  // refused addresses, masked store, high nibble width, reset in mid-run
  task automatic sc_refuse();
    logic [7:0]  bad [3];
    logic [31:0] r;
    logic        err;
    bad = '{8'h3c, 8'h40, 8'h02};
    foreach (bad[i]) begin
      acc(1'b0, bad[i], 32'h0, 4'h0, r, err);
      check({r[31:1], err}, 32'h1);
    end
    set_ptr(8'h00, 12'h200);
    wr(OFS_PLAIN, 8'h55);
    acc(1'b1, OFS_POSTINC, 32'h77, 4'h0, r, err);
    rd_ptr(8'h00, 12'h201);
    set_ptr(8'h00, 12'h200);
    rd(OFS_PLAIN, 32'h55);
    wr(OFS_PTR_HIGH, 8'hff);
    rd(OFS_PTR_HIGH, 32'h0f);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check({30'h0, pready, pslverr}, 32'h0);
    presetn <= 1'b1;
    rd(OFS_PTR_HIGH, 32'h0);
    rd(SET1_BASE + OFS_PTR_HIGH, 32'h0);
    rd(SET1_BASE + OFS_PTR_LOW, 32'h02);
  endtask : sc_refuse

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    err_count = 0;
    checks    = 0;
    presetn   = 1'b0;
    repeat (8) @(posedge pclk);
    check(prdata, 32'h0);
    presetn <= 1'b1;
    sc_reset();
    sc_postinc();
    sc_dec_inc();
    sc_offset();
    sc_set1();
    sc_refuse();
    tally_and_finish();
  end
endmodule : indirect_data_pointer_unit_tb
